// ===== dv/gpio_port_block_properties.sv
// Concurrent checks on the port block's pins, requests and bus answer.
module gpio_port_block_properties #(
    parameter WIDTH     = 8,
    parameter NUM_PORTS = 3
) (
    input wire                       clock,
    input wire                       reset_n,
    input wire                       read,
    input wire                       write,
    input wire                       waitrequest,
    input wire [NUM_PORTS*WIDTH-1:0] pin_in,
    input wire [NUM_PORTS*WIDTH-1:0] pin_out,
    input wire [NUM_PORTS*WIDTH-1:0] pin_oe,
    input wire [NUM_PORTS*WIDTH-1:0] pull_up_en,
    input wire [NUM_PORTS*WIDTH-1:0] analog_sel,
    input wire                       vec1_irq_req,
    input wire                       vec2_irq_req,
    input wire                       wake_req,
    input wire                       irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_wait_one_cycle: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("Bus answer not after one wait.");
    a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
        else $error("Wait raised with no request.");
    a_oe_no_pullup: assert property ((pin_oe & pull_up_en) == 0)
        else $error("Pull-up on a driven pin.");
    a_analog_excl: assert property (
        (analog_sel & (pull_up_en | pin_oe)) == 0)
        else $error("Analog pin also pulled or driven.");
    a_high_needs_oe: assert property ((pin_out & ~pin_oe) == 0)
        else $error("High level without output enable.");
    a_wake_follows: assert property (
        wake_req == (vec1_irq_req || vec2_irq_req))
        else $error("Wake request not tied to port requests.");
    a_irq_has_cause: assert property ($rose(irq) |->
        $past(vec1_irq_req || vec2_irq_req))
        else $error("Interrupt rose without a port request.");
    a_edge_synced: assert property (vec2_irq_req |->
        $past(pin_in[NUM_PORTS*WIDTH-1:WIDTH], 2)
        != $past(pin_in[NUM_PORTS*WIDTH-1:WIDTH], 3))
        else $error("Edge request not two cycles after a pin change.");
endmodule // gpio_port_block_properties

bind gpio_port_block gpio_port_block_properties #(.WIDTH(WIDTH),
    .NUM_PORTS(NUM_PORTS)) CHK (.clock(clock), .reset_n(reset_n),
    .read(read), .write(write), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .analog_sel(analog_sel),
    .vec1_irq_req(vec1_irq_req), .vec2_irq_req(vec2_irq_req),
    .wake_req(wake_req), .irq(irq));

// ===== dv/gpio_port_block_tb.sv
// Self-checking bench for the three-port pin block over its register bus.
`include "gpio_port_consts.vh"
module gpio_port_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset_n, read, write;
    logic [11:0] address;
    logic [31:0] writedata;
    wire  [31:0] readdata;
    wire         waitrequest, vec1, vec2, wake_req, irq;
    wire  [23:0] pin_in, pin_out, pin_oe, pull_up_en, analog_sel;
    logic [23:0] ext_en, ext_val;
    int          bad_count, checked, cyc, v2_cnt;

    gpio_port_block DUT (.clock(clock), .reset_n(reset_n),
        .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pull_up_en(pull_up_en), .analog_sel(analog_sel),
        .vec1_irq_req(vec1), .vec2_irq_req(vec2), .wake_req(wake_req),
        .irq(irq));
    pin_pad_model PADS (.clock(clock), .pin_oe(pin_oe), .pin_out(pin_out),
        .pull_up_en(pull_up_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // Free-running clock at 4 ns.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Count edge pulses and cut a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (vec2 === 1'b1) v2_cnt <= v2_cnt + 1;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input string n, input [31:0] s, input [31:0] e);
        checked++;
        if (s !== e) begin
            $display("ERROR %s expected %0h seen %0h", n, e, s);
            bad_count++;
        end
    endtask

    // One bus access; held until waitrequest is seen low at a rising edge,
    // where read data is taken and the request is then released.
    task automatic acc(input bit w, input [9:0] i, input [7:0] d,
                       output [31:0] q);
        @(posedge clock);
        address <= {i, 2'b00};
        writedata <= {24'h000000, d};
        read <= !w;
        write <= w;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input [9:0] i, input [7:0] d);
        logic [31:0] q;
        acc(1'b1, i, d, q);
    endtask

    task automatic rc(input [9:0] i, input [31:0] e, input string n);
        logic [31:0] q;
        acc(1'b0, i, 8'h00, q);
        chk(n, q, e);
    endtask

    task automatic settle();
        repeat (6) @(posedge clock);
        @(negedge clock);
    endtask

    task test_done();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Software side writes whole bytes; two analog pins, A0 and A2, are selected only briefly as port A turns input.
    initial begin
        {reset_n, read, write, address, writedata} = '0;
        {ext_en, ext_val, bad_count, checked, cyc, v2_cnt} = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        settle();
        chk("pull_up_en", pull_up_en, 24'hffffff);
        chk("pin_oe", pin_oe, 24'h000000);
        for (int k = 0; k < 3; k++) begin
            rc(10'(`IDX_DIR_A + k), 0, "dir");
            rc(10'(`IDX_OPT_A + k), 0, "opt");
            rc(10'(`IDX_DATA_A + k), 8'hff, "data");
        end
        rc(10'h3ff, 0, "unmapped");
        rc(`IDX_IRQ_OPTION, 0, "option");
        wr(`IDX_DIR_A, 8'hff);
        wr(`IDX_OPT_A, 8'h0f);
        wr(`IDX_DATA_A, 8'ha5);
        @(negedge clock);
        chk("oe_a", pin_oe[7:0], 8'h5f);
        chk("out_a", pin_out[7:0], 8'h05);
        rc(`IDX_DATA_A, 8'ha5, "latch_a");
        wr(`IDX_OPT_B, 8'h0c);
        wr(`IDX_DATA_B, 8'h0a);
        @(negedge clock);
        chk("pull_b", pull_up_en[15:8], 8'hf5);
        chk("analog_b", analog_sel[15:8], 8'h08);
        chk("oe_b", pin_oe[15:8], 8'h00);
        // Edges on port C with no interrupt set-up must stay silent.
        @(posedge clock);
        ext_en[23:16] <= 8'hff;
        ext_val[23:16] <= 8'h3c;
        settle();
        rc(`IDX_DATA_C, 8'h3c, "pins_c");
        wr(`IDX_DATA_B, 8'h00);
        wr(`IDX_IRQ_MASK, 8'h02);
        // Board holds pin B2 high first so the first step is a true fall.
        @(posedge clock);
        ext_en[10] <= 1'b1;
        ext_val[10] <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(`IDX_IRQ_OPTION, m ? 8'h30 : 8'h10);
            @(posedge clock);
            ext_val[10] <= m[0];
            settle();
            chk("edges", v2_cnt, m + 1);
            chk("irq", irq, 1);
            rc(`IDX_IRQ_STATUS, 2, "status");
            wr(`IDX_IRQ_STATUS, 8'h02);
            rc(`IDX_IRQ_STATUS, 0, "cleared");
            chk("irq_off", irq, 0);
        end
        // A matching falling edge with the global allow bit clear is dropped.
        wr(`IDX_IRQ_OPTION, 8'h00);
        @(posedge clock);
        ext_val[10] <= 1'b0;
        settle();
        rc(`IDX_IRQ_STATUS, 0, "gated");
        wr(`IDX_DIR_A, 8'h00);
        wr(`IDX_OPT_A, 8'h01);
        wr(`IDX_DATA_A, 8'h00);
        wr(`IDX_IRQ_STATUS, 8'h03);
        wr(`IDX_IRQ_MASK, 8'h01);
        wr(`IDX_IRQ_OPTION, 8'h50);
        @(posedge clock);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b0;
        settle();
        wr(`IDX_IRQ_STATUS, 8'h01);
        rc(`IDX_IRQ_STATUS, 1, "level_held");
        chk("irq_a", irq, 1);
        @(posedge clock);
        ext_val[0] <= 1'b1;
        settle();
        wr(`IDX_IRQ_STATUS, 8'h01);
        rc(`IDX_IRQ_STATUS, 0, "level_gone");
        chk("irq_a_off", irq, 0);
        test_done();
    end
endmodule // gpio_port_block_tb

// ===== dv/pin_pad_model.sv
// Board-side pad model: resolves each pin from the device, board and pull-up.
module pin_pad_model (
    input  wire         clock,
    input  wire  [23:0] pin_oe,
    input  wire  [23:0] pin_out,
    input  wire  [23:0] pull_up_en,
    input  wire  [23:0] ext_en,
    input  wire  [23:0] ext_val,
    output logic [23:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] flt_ff;

    // A pin nobody holds wanders, so a stale level can never pass for data.
    initial flt_ff = 24'h5a5a5a;
    always @(posedge clock) flt_ff <= ~flt_ff;

    // Device drive wins, then board drive, then pull-up; open drain floats.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_en | flt_ff));
endmodule // pin_pad_model

// ===== src/gpio_port_block.v
// Three bidirectional eight-pin ports behind an Avalon-MM register slave.
`include "gpio_port_consts.vh"

// Notes on behaviour
// - eight pins, each set by same-numbered bits
// - reset clears registers; inputs with pull-up
// - input sub-mode from option and data bits
// - output option picks open-drain or push-pull
// - input pins read back the pin level
// - output pins drive and read the latch
// - push-pull drives both levels; open-drain floats high
// - interrupt needs interrupt input and global allow
// - trigger type chosen per vector (ports B and C share one), not pin
// - alternate role only through the port registers
// - low power keeps pins; port interrupt wakes
// - first port falling edge or low level
// - second and third ports falling or rising
module gpio_port_block #(
    parameter WIDTH     = 8,
    parameter NUM_PORTS = 3
) (
    input  wire                       clock,
    input  wire                       reset_n,
    input  wire [11:0]                address,
    input  wire                       read,
    input  wire                       write,
    input  wire [3:0]                 byteenable,
    input  wire [31:0]                writedata,
    output wire [31:0]                readdata,
    output wire                       waitrequest,
    input  wire [NUM_PORTS*WIDTH-1:0] pin_in,
    output wire [NUM_PORTS*WIDTH-1:0] pin_out,
    output wire [NUM_PORTS*WIDTH-1:0] pin_oe,
    output wire [NUM_PORTS*WIDTH-1:0] pull_up_en,
    output wire [NUM_PORTS*WIDTH-1:0] analog_sel,
    output wire                       vec1_irq_req,
    output wire                       vec2_irq_req,
    output wire                       wake_req,
    output wire                       irq
);

    // Reset release goes through two flops; assertion stays asynchronous.
    reg                       rst_meta_ff;
    reg                       rst_sync_ff;
    wire                      rst_n;

    // Bus handshake state.
    reg                       ack_ff;
    reg  [31:0]               readdata_ff;
    wire                      req;
    wire [9:0]                index;
    wire                      commit_wr;

    // Interrupt option bits and the software interrupt registers.
    reg                       first_port_level_select_ff;
    reg                       second_vector_edge_select_ff;
    reg                       global_irq_allow_ff;
    reg  [1:0]                irq_status_ff;
    reg  [1:0]                irq_mask_ff;
    reg  [1:0]                nxt_irq_status;

    // Per-port views and strobes.
    wire [NUM_PORTS*WIDTH-1:0] data_view;
    wire [NUM_PORTS*WIDTH-1:0] dir_view;
    wire [NUM_PORTS*WIDTH-1:0] opt_view;
    wire [NUM_PORTS-1:0]       port_event;
    wire [NUM_PORTS-1:0]       wr_data;
    wire [NUM_PORTS-1:0]       wr_dir;
    wire [NUM_PORTS-1:0]       wr_opt;
    wire [2*NUM_PORTS-1:0]     trig_mode;
    wire                       vec1_event;
    wire                       vec2_event;
    reg  [31:0]                nxt_readdata;

    // Two-flop reset release so every flop leaves reset on one edge.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // Every access waits exactly one cycle; read data is captured during
    // the wait so it is stable at the edge where waitrequest is low.
    assign req         = read | write;
    assign waitrequest = req & ~ack_ff;
    assign index       = address[11:2];
    assign commit_wr   = write & ack_ff & byteenable[0];
    assign readdata    = readdata_ff;

    // Acknowledge flop alternates so back-to-back requests each get a wait.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Write strobes toward each port slice, one per register kind.
    assign wr_data[0] = commit_wr & (index == `IDX_DATA_A);
    assign wr_data[1] = commit_wr & (index == `IDX_DATA_B);
    assign wr_data[2] = commit_wr & (index == `IDX_DATA_C);
    assign wr_dir[0]  = commit_wr & (index == `IDX_DIR_A);
    assign wr_dir[1]  = commit_wr & (index == `IDX_DIR_B);
    assign wr_dir[2]  = commit_wr & (index == `IDX_DIR_C);
    assign wr_opt[0]  = commit_wr & (index == `IDX_OPT_A);
    assign wr_opt[1]  = commit_wr & (index == `IDX_OPT_B);
    assign wr_opt[2]  = commit_wr & (index == `IDX_OPT_C);

    // The first port chooses falling edge or low level.
    assign trig_mode[1:0] = first_port_level_select_ff ?
                            `TRIG_LOW : `TRIG_FALL;
    // The second and third ports share one falling or rising choice.
    assign trig_mode[3:2] = second_vector_edge_select_ff ?
                            `TRIG_RISE : `TRIG_FALL;
    assign trig_mode[5:4] = trig_mode[3:2];

    // One slice per port; each pin is set by its own bit of each register.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            pin_port_slice #(
                .WIDTH (WIDTH)
            ) u_slice (
                .clock      (clock),
                .rst_n      (rst_n),
                .wr_data    (wr_data[p]),
                .wr_dir     (wr_dir[p]),
                .wr_opt     (wr_opt[p]),
                .wdata      (writedata[WIDTH-1:0]),
                .trig_mode  (trig_mode[2*p+1:2*p]),
                .pin_in     (pin_in[WIDTH*p+WIDTH-1:WIDTH*p]),
                .pin_out    (pin_out[WIDTH*p+WIDTH-1:WIDTH*p]),
                .pin_oe     (pin_oe[WIDTH*p+WIDTH-1:WIDTH*p]),
                .pull_up_en (pull_up_en[WIDTH*p+WIDTH-1:WIDTH*p]),
                .analog_sel (analog_sel[WIDTH*p+WIDTH-1:WIDTH*p]),
                .data_view  (data_view[WIDTH*p+WIDTH-1:WIDTH*p]),
                .dir_view   (dir_view[WIDTH*p+WIDTH-1:WIDTH*p]),
                .opt_view   (opt_view[WIDTH*p+WIDTH-1:WIDTH*p]),
                .irq_event  (port_event[p])
            );
        end
    endgenerate

    // Interrupt option register; reserved bits are dropped on write.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_port_level_select_ff   <= 1'b0;
            second_vector_edge_select_ff <= 1'b0;
            global_irq_allow_ff          <= 1'b0;
        end else if (commit_wr && (index == `IDX_IRQ_OPTION)) begin
            first_port_level_select_ff   <= writedata[`IOR_LEVEL_BIT];
            second_vector_edge_select_ff <= writedata[`IOR_EDGE_BIT];
            global_irq_allow_ff          <= writedata[`IOR_GLOBAL_BIT];
        end
    end

    // Vector requests leave only while the global allow bit is set.
    assign vec1_event   = port_event[0];
    assign vec2_event   = port_event[1] | port_event[2];
    assign vec1_irq_req = global_irq_allow_ff & vec1_event;
    assign vec2_irq_req = global_irq_allow_ff & vec2_event;
    // Pins are never touched by low power; any allowed request wakes.
    assign wake_req     = vec1_irq_req | vec2_irq_req;

    // Sticky status: a new event in the clearing cycle keeps its bit.
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (commit_wr && (index == `IDX_IRQ_STATUS)) begin
            nxt_irq_status = irq_status_ff & ~writedata[1:0];
        end
        nxt_irq_status[`STAT_VEC1_BIT] =
            nxt_irq_status[`STAT_VEC1_BIT] | vec1_irq_req;
        nxt_irq_status[`STAT_VEC2_BIT] =
            nxt_irq_status[`STAT_VEC2_BIT] | vec2_irq_req;
    end

    // Status and mask registers.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_ff <= `RST_IRQ_BITS;
            irq_mask_ff   <= `RST_IRQ_BITS;
        end else begin
            irq_status_ff <= nxt_irq_status;
            if (commit_wr && (index == `IDX_IRQ_MASK)) begin
                irq_mask_ff <= writedata[1:0];
            end
        end
    end

    // Level output: high while any unmasked status bit is set.
    assign irq = |(irq_status_ff & irq_mask_ff);

    // Read mux. The option register is write-only and reads as zero, as
    // does any unmapped index; reads have no side effects.
    always @* begin
        nxt_readdata = 32'h0000_0000;
        case (index)
            `IDX_DATA_A:     nxt_readdata[7:0] = data_view[7:0];
            `IDX_DATA_B:     nxt_readdata[7:0] = data_view[15:8];
            `IDX_DATA_C:     nxt_readdata[7:0] = data_view[23:16];
            `IDX_DIR_A:      nxt_readdata[7:0] = dir_view[7:0];
            `IDX_DIR_B:      nxt_readdata[7:0] = dir_view[15:8];
            `IDX_DIR_C:      nxt_readdata[7:0] = dir_view[23:16];
            `IDX_OPT_A:      nxt_readdata[7:0] = opt_view[7:0];
            `IDX_OPT_B:      nxt_readdata[7:0] = opt_view[15:8];
            `IDX_OPT_C:      nxt_readdata[7:0] = opt_view[23:16];
            `IDX_IRQ_STATUS: nxt_readdata[1:0] = irq_status_ff;
            `IDX_IRQ_MASK:   nxt_readdata[1:0] = irq_mask_ff;
            default:         nxt_readdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the wait cycle and held until the next read.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

endmodule // gpio_port_block

// ===== src/gpio_port_consts.vh
// Constants shared by the bidirectional port block: indices, fields, resets.
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// Register indices; the bus byte address is four times the index.
`define IDX_DATA_A      10'h0c0
`define IDX_DATA_B      10'h0c1
`define IDX_DATA_C      10'h0c2
`define IDX_DIR_A       10'h0c4
`define IDX_DIR_B       10'h0c5
`define IDX_DIR_C       10'h0c6
`define IDX_IRQ_OPTION  10'h0c8
`define IDX_OPT_A       10'h0cc
`define IDX_OPT_B       10'h0cd
`define IDX_OPT_C       10'h0ce
`define IDX_IRQ_STATUS  10'h0d0
`define IDX_IRQ_MASK    10'h0d1

// Field positions in the interrupt option register.
`define IOR_LEVEL_BIT   6
`define IOR_EDGE_BIT    5
`define IOR_GLOBAL_BIT  4

// Field positions in the interrupt status and mask registers.
`define STAT_VEC1_BIT   0
`define STAT_VEC2_BIT   1

// Reset values.
`define RST_PORT_REG    8'h00
`define RST_IOR_BITS    3'h0
`define RST_IRQ_BITS    2'h0

// Interrupt trigger encodings handed to each port slice.
`define TRIG_FALL       2'h0
`define TRIG_RISE       2'h1
`define TRIG_LOW        2'h2

`endif

// ===== src/pin_port_slice.v
// One eight-pin port: its three registers, pad drive, input sync, triggers.
`include "gpio_port_consts.vh"

module pin_port_slice #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             wr_data,
    input  wire             wr_dir,
    input  wire             wr_opt,
    input  wire [WIDTH-1:0] wdata,
    input  wire [1:0]       trig_mode,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe,
    output wire [WIDTH-1:0] pull_up_en,
    output wire [WIDTH-1:0] analog_sel,
    output wire [WIDTH-1:0] data_view,
    output wire [WIDTH-1:0] dir_view,
    output wire [WIDTH-1:0] opt_view,
    output wire             irq_event
);

    reg  [WIDTH-1:0] data_ff;
    reg  [WIDTH-1:0] dir_ff;
    reg  [WIDTH-1:0] opt_ff;
    reg  [WIDTH-1:0] sync1_ff;
    reg  [WIDTH-1:0] sync2_ff;
    reg  [WIDTH-1:0] prev_ff;
    wire [WIDTH-1:0] irq_pin_en;
    wire [WIDTH-1:0] hit;

    // Registers clear at reset, so every pin starts as input with pull-up.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= `RST_PORT_REG;
            dir_ff  <= `RST_PORT_REG;
            opt_ff  <= `RST_PORT_REG;
        end else begin
            if (wr_data) begin
                data_ff <= wdata;
            end
            if (wr_dir) begin
                dir_ff <= wdata;
            end
            if (wr_opt) begin
                opt_ff <= wdata;
            end
        end
    end

    // Two flops guard against metastability; prev_ff only sees settled data.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= {WIDTH{1'b1}};
            sync2_ff <= {WIDTH{1'b1}};
            prev_ff  <= {WIDTH{1'b1}};
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Pin modes decode bit by bit from direction, option and data.
    // Peripherals never take a pin over; only these bits select its role.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            assign pull_up_en[i] = ~dir_ff[i] & ~data_ff[i];
            assign analog_sel[i] = ~dir_ff[i] & opt_ff[i] &
                                   data_ff[i];
            assign irq_pin_en[i] = ~dir_ff[i] & opt_ff[i] &
                                   ~data_ff[i];
            // Open-drain keeps the high side off, so a one only releases.
            assign pin_oe[i]  = dir_ff[i] & (opt_ff[i] | ~data_ff[i]);
            assign pin_out[i] = dir_ff[i] & opt_ff[i] & data_ff[i];
            // Inputs read the synchronised pin, outputs the latch.
            assign data_view[i] = dir_ff[i] ? data_ff[i] : sync2_ff[i];
            assign hit[i] = (trig_mode == `TRIG_LOW)  ? ~sync2_ff[i] :
                            (trig_mode == `TRIG_RISE) ?
                                (sync2_ff[i] & ~prev_ff[i]) :
                                (~sync2_ff[i] & prev_ff[i]);
        end
    endgenerate

    assign dir_view  = dir_ff;
    assign opt_view  = opt_ff;
    // Only pins set up for interrupt input may raise the port event.
    assign irq_event = |(hit & irq_pin_en);

endmodule // pin_port_slice
